// ==== design/irqfe_params.svh ====
`ifndef IRQFE_PARAMS_SVH
`define IRQFE_PARAMS_SVH

// Byte addresses of the register words.
`define IRQFE_OFF_NORMAL_STATUS 32'hFFFF_F000
`define IRQFE_OFF_FAST_STATUS 32'hFFFF_F004
`define IRQFE_OFF_RAW_STATUS 32'hFFFF_F008
`define IRQFE_OFF_CLASS_SELECT 32'hFFFF_F00C
`define IRQFE_OFF_ENABLE_SET 32'hFFFF_F010
`define IRQFE_OFF_ENABLE_CLEAR 32'hFFFF_F014
`define IRQFE_OFF_FORCE_SET 32'hFFFF_F018
`define IRQFE_OFF_FORCE_CLEAR 32'hFFFF_F01C

// Reset values of the stored registers.
`define IRQFE_RST_CLASS 32'h0000_0000
`define IRQFE_RST_ENABLE 32'h0000_0000
`define IRQFE_RST_FORCE 32'h0000_0000

// Number of request inputs.
`define IRQFE_NUM_REQ 32

`endif

// ==== design/irqfe_pkg.sv ====
package irqfe_pkg;
	typedef logic [31:0] irqfe_word_t;
	typedef enum logic [3:0] {
		IRQFE_SEL_NONE = 4'b0000,
		IRQFE_SEL_NORMAL = 4'b0001,
		IRQFE_SEL_FAST = 4'b0010,
		IRQFE_SEL_RAW = 4'b0011,
		IRQFE_SEL_CLASS = 4'b0100,
		IRQFE_SEL_ENABLE = 4'b0101,
		IRQFE_SEL_ENCLR = 4'b0110,
		IRQFE_SEL_FSET = 4'b0111,
		IRQFE_SEL_FCLR = 4'b1000
	} irqfe_sel_e;
endpackage

// ==== design/irqfe_req_if.sv ====
`timescale 1ns/1ps
interface irqfe_req_if;
	logic [31:0] raw;
	logic [31:0] enable;
	logic [31:0] fast_sel;
	logic [31:0] normal_status;
	logic [31:0] fast_status;
	modport ctrl (output raw, output enable, output fast_sel,
		input normal_status, input fast_status);
	modport classify (input raw, input enable, input fast_sel,
		output normal_status, output fast_status);
endinterface

// ==== design/irqfe_classify.sv ====
`timescale 1ns/1ps
`include "irqfe_params.svh"
module irqfe_classify
	import irqfe_pkg::*;
(
	// Request vectors.
	irqfe_req_if.classify req
);
	genvar i;
	generate
		for (i = 0; i < `IRQFE_NUM_REQ; i++) begin : g_bit
			// A set class bit means fast, clear means normal.
			assign req.normal_status[i] = req.raw[i] & req.enable[i] &
				~req.fast_sel[i];
			assign req.fast_status[i] = req.raw[i] & req.enable[i] &
				req.fast_sel[i];
		end
	endgenerate
endmodule

// ==== design/irqfe_top.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "irqfe_params.svh"
// Function
// - Each peripheral request is ORed with its software-force bit first.
// - Writing ones to the force-set register forces those requests.
// - Writing ones to the force-clear register releases those forces.
// - Raw status reads combined requests, ignoring enable and class.
// - Only enabled requests reach the fast or normal line.
// - Reading the enable register returns the current enable bits.
// - Writing ones to the enable register sets those enables.
// - Writing ones to the enable-clear register clears those enables.
// - Each class select bit puts its request in fast or normal.
// - Normal status shows enabled, normal-class, asserted requests.
// - Normal status carries no vectoring information.
// - Fast status shows enabled, fast-class, asserted requests.
// - Fast status flags every active fast request at once.
module irqfe_top
	import irqfe_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral requests.
	input wire logic [31:0] periph_req,
	// Toward the core and the vectored priority logic.
	output logic fast_interrupt_line,
	output logic [31:0] normal_irq_pending
);
	irqfe_req_if req ();

	irqfe_word_t class_r, class_nxt;
	irqfe_word_t enable_r, enable_nxt;
	irqfe_word_t force_r, force_nxt;
	irqfe_word_t rdata_r, rdata_nxt;
	logic fast_r, fast_nxt;
	irqfe_word_t normal_r, normal_nxt;
	irqfe_sel_e sel;
	logic wr_en;
	logic rd_en;

	function automatic irqfe_sel_e decode(input logic [31:0] a);
		unique case (a)
			`IRQFE_OFF_NORMAL_STATUS: decode = IRQFE_SEL_NORMAL;
			`IRQFE_OFF_FAST_STATUS: decode = IRQFE_SEL_FAST;
			`IRQFE_OFF_RAW_STATUS: decode = IRQFE_SEL_RAW;
			`IRQFE_OFF_CLASS_SELECT: decode = IRQFE_SEL_CLASS;
			`IRQFE_OFF_ENABLE_SET: decode = IRQFE_SEL_ENABLE;
			`IRQFE_OFF_ENABLE_CLEAR: decode = IRQFE_SEL_ENCLR;
			`IRQFE_OFF_FORCE_SET: decode = IRQFE_SEL_FSET;
			`IRQFE_OFF_FORCE_CLEAR: decode = IRQFE_SEL_FCLR;
			default: decode = IRQFE_SEL_NONE;
		endcase
	endfunction

	assign req.raw = periph_req | force_r;
	assign req.enable = enable_r;
	assign req.fast_sel = class_r;
	irqfe_classify u_classify (
		.req(req)
	);

	// The slave answers in the first access cycle, so no wait states.
	assign sel = decode(paddr);
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = rdata_r;
	assign fast_interrupt_line = fast_r;
	assign normal_irq_pending = normal_r;

	// Ones in the written word set or clear the matching bits.
	function automatic irqfe_word_t set_ones(input irqfe_word_t cur,
		input irqfe_word_t wd);
		set_ones = cur | wd;
	endfunction

	function automatic irqfe_word_t clear_ones(input irqfe_word_t cur,
		input irqfe_word_t wd);
		clear_ones = cur & ~wd;
	endfunction

	always_comb begin
		class_nxt = class_r;
		if (wr_en && sel == IRQFE_SEL_CLASS) begin
			class_nxt = pwdata;
		end
	end

	always_comb begin
		enable_nxt = enable_r;
		if (wr_en && sel == IRQFE_SEL_ENABLE) begin
			enable_nxt = set_ones(enable_r, pwdata);
		end else if (wr_en && sel == IRQFE_SEL_ENCLR) begin
			enable_nxt = clear_ones(enable_r, pwdata);
		end
	end

	// Set and clear sit at separate addresses, so they never meet.
	always_comb begin
		force_nxt = force_r;
		if (wr_en && sel == IRQFE_SEL_FSET) begin
			force_nxt = set_ones(force_r, pwdata);
		end else if (wr_en && sel == IRQFE_SEL_FCLR) begin
			force_nxt = clear_ones(force_r, pwdata);
		end
	end

	// Read data is captured in the setup cycle and held through access.
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_en) begin
			unique case (sel)
				IRQFE_SEL_NORMAL: rdata_nxt = req.normal_status;
				IRQFE_SEL_FAST: rdata_nxt = req.fast_status;
				IRQFE_SEL_RAW: rdata_nxt = req.raw;
				IRQFE_SEL_CLASS: rdata_nxt = class_r;
				IRQFE_SEL_ENABLE: rdata_nxt = enable_r;
				IRQFE_SEL_FSET: rdata_nxt = force_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		fast_nxt = |req.fast_status;
		normal_nxt = req.normal_status;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			class_r <= `IRQFE_RST_CLASS;
		end else begin
			class_r <= class_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= `IRQFE_RST_ENABLE;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= `IRQFE_RST_FORCE;
		end else begin
			force_r <= force_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_r <= 1'b0;
			normal_r <= 32'h0000_0000;
		end else begin
			fast_r <= fast_nxt;
			normal_r <= normal_nxt;
		end
	end

	// Stored words change only through their own write addresses.
	force_set_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_en && sel == IRQFE_SEL_FSET |=>
		force_r == ($past(force_r) | $past(pwdata)))
		else $error("force set write wrong");

	force_clear_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_en && sel == IRQFE_SEL_FCLR |=>
		force_r == ($past(force_r) & ~$past(pwdata)))
		else $error("force clear write wrong");

	force_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(wr_en && (sel == IRQFE_SEL_FSET || sel == IRQFE_SEL_FCLR))
		|=> $stable(force_r))
		else $error("force bits moved without a write");

	enable_set_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_en && sel == IRQFE_SEL_ENABLE |=>
		enable_r == ($past(enable_r) | $past(pwdata)))
		else $error("enable set write wrong");

	enable_clear_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_en && sel == IRQFE_SEL_ENCLR |=>
		enable_r == ($past(enable_r) & ~$past(pwdata)))
		else $error("enable clear write wrong");

	enable_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(wr_en && (sel == IRQFE_SEL_ENABLE || sel == IRQFE_SEL_ENCLR))
		|=> $stable(enable_r))
		else $error("enable bits moved without a write");

	class_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_en && sel == IRQFE_SEL_CLASS |=>
		class_r == $past(pwdata))
		else $error("class write wrong");

	class_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(wr_en && sel == IRQFE_SEL_CLASS) |=> $stable(class_r))
		else $error("class bits moved without a write");

	// Read data shows the state sampled at the setup edge.
	raw_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_RAW |=>
		prdata == ($past(periph_req) | $past(force_r)))
		else $error("raw status read wrong");

	enable_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_ENABLE |=>
		prdata == $past(enable_r))
		else $error("enable read wrong");

	class_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_CLASS |=>
		prdata == $past(class_r))
		else $error("class read wrong");

	force_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_FSET |=>
		prdata == $past(force_r))
		else $error("force read wrong");

	normal_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_NORMAL |=>
		prdata == (($past(periph_req) | $past(force_r)) &
		$past(enable_r) & ~$past(class_r)))
		else $error("normal status read wrong");

	fast_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && sel == IRQFE_SEL_FAST |=>
		prdata == (($past(periph_req) | $past(force_r)) &
		$past(enable_r) & $past(class_r)))
		else $error("fast status read wrong");

	wronly_read_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_en && (sel == IRQFE_SEL_ENCLR || sel == IRQFE_SEL_FCLR ||
		sel == IRQFE_SEL_NONE) |=> prdata == 32'h0000_0000)
		else $error("write-only or unmapped read not zero");

	// The classifier splits enabled requests by class bit.
	normal_class_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		req.normal_status ==
		((periph_req | force_r) & enable_r & ~class_r))
		else $error("normal classification wrong");

	fast_class_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		req.fast_status ==
		((periph_req | force_r) & enable_r & class_r))
		else $error("fast classification wrong");

	class_disjoint_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		(req.normal_status & req.fast_status) == 32'h0000_0000)
		else $error("class overlap");

	// The outgoing lines trail the status by one cycle.
	normal_status_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		##1 normal_irq_pending ==
		(($past(periph_req) | $past(force_r)) & $past(enable_r) &
		~$past(class_r)))
		else $error("normal status wrong");

	fast_line_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		##1 fast_interrupt_line ==
		(|(($past(periph_req) | $past(force_r)) & $past(enable_r) &
		$past(class_r))))
		else $error("fast line wrong");

	disabled_quiet_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		enable_r == 32'h0000_0000 |=> !fast_interrupt_line &&
		normal_irq_pending == 32'h0000_0000)
		else $error("disabled request reached a line");

	forced_fast_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		(force_r & enable_r & class_r) != 32'h0000_0000 |=>
		fast_interrupt_line)
		else $error("forced fast request missed the line");

	fast_line_low_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		class_r == 32'h0000_0000 |=> !fast_interrupt_line)
		else $error("fast line high with no fast class");
endmodule

// ==== testbench/irqfe_periph_model.sv ====
`timescale 1ns/1ps
module irqfe_periph_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Pattern asked for by the bench.
	input wire logic [31:0] req_cmd,
	// Request levels toward the block.
	output logic [31:0] periph_req
);
	// Peripherals raise levels synchronously, one edge after the command.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_req <= 32'h0000_0000;
		end else begin
			periph_req <= req_cmd;
		end
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "irqfe_params.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fline;
	logic [31:0] paddr, pwdata, prdata, req_cmd, periph_req, pend;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	irqfe_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(periph_req),
		.fast_interrupt_line(fline), .normal_irq_pending(pend));
	irqfe_periph_model peer (.pclk(pclk), .presetn(presetn),
		.req_cmd(req_cmd), .periph_req(periph_req));
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Called just after a rising edge; leaves one idle cycle behind it.
	task automatic apb(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		`CHK("pslverr", 1'b0, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [31:0] a, e, input string n);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		`CHK(n, e, r)
	endtask
	// Pins lag the registers by one cycle.
	task automatic pins(input logic f, input logic [31:0] n);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("fast line", f, fline)
		`CHK("pending", n, pend)
		@(posedge pclk);
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite} = 4'b0000;
		{paddr, pwdata, req_cmd} = {3{32'h0000_0000}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`IRQFE_OFF_CLASS_SELECT, 32'h0000_0000, "class");
		rd(`IRQFE_OFF_ENABLE_SET, 32'h0000_0000, "enable");
		rd(`IRQFE_OFF_FORCE_SET, 32'h0000_0000, "force");
		$display("reset test done");
		req_cmd <= 32'h0000_00F0;
		wr(`IRQFE_OFF_ENABLE_SET, 32'h0000_0FF0);
		wr(`IRQFE_OFF_CLASS_SELECT, 32'h0000_0330);
		rd(`IRQFE_OFF_RAW_STATUS, 32'h0000_00F0, "raw");
		rd(`IRQFE_OFF_FAST_STATUS, 32'h0000_0030, "fast");
		rd(`IRQFE_OFF_NORMAL_STATUS, 32'h0000_00C0, "normal");
		pins(1'b1, 32'h0000_00C0);
		$display("class test done");
		wr(`IRQFE_OFF_FORCE_SET, 32'h0000_0300);
		wr(`IRQFE_OFF_FORCE_SET, 32'h0000_0000);
		rd(`IRQFE_OFF_RAW_STATUS, 32'h0000_03F0, "raw");
		rd(`IRQFE_OFF_FAST_STATUS, 32'h0000_0330, "fast");
		wr(`IRQFE_OFF_FORCE_CLEAR, 32'h0000_0100);
		rd(`IRQFE_OFF_FORCE_SET, 32'h0000_0200, "force");
		rd(`IRQFE_OFF_FORCE_CLEAR, 32'h0000_0000, "force clear");
		$display("force test done");
		wr(`IRQFE_OFF_ENABLE_CLEAR, 32'h0000_00F0);
		rd(`IRQFE_OFF_ENABLE_SET, 32'h0000_0F00, "enable");
		rd(`IRQFE_OFF_NORMAL_STATUS, 32'h0000_0000, "normal");
		rd(`IRQFE_OFF_FAST_STATUS, 32'h0000_0200, "fast");
		wr(`IRQFE_OFF_CLASS_SELECT, 32'h0000_0000);
		pins(1'b0, 32'h0000_0200);
		rd(32'hFFFF_F0F0, 32'h0000_0000, "unmapped");
		$display("enable test done");
		summarize();
	end
endmodule
